// >>> plsc_pkg.sv
// Purpose: Shared constants for the loop-two lock/status control slice
// Assumes: Byte-wide registers on the serial control port
// Notes: Offsets are byte register numbers
package plsc_pkg;
    localparam int ADDR_W = 12;
    localparam int CNT_W = 14;
    localparam logic [11:0] OFS_LOCK_COUNT_HIGH = 12'h16A;
    localparam logic [11:0] OFS_LOCK_COUNT_LOW = 12'h16B;
    localparam logic [11:0] OFS_STATUS_PIN_TWO_SELECT = 12'h16E;
    localparam logic [11:0] OFS_LOOP_TWO_POWERDOWN = 12'h173;
    localparam logic [11:0] OFS_REF_DIVIDER_HOLD = 12'h177;
    // Field positions
    localparam int SEL_LSB = 3;
    localparam int TYPE_LSB = 0;
    localparam int PRE_PD_BIT = 6;
    localparam int LOOP_PD_BIT = 5;
    localparam int FB_PD_BIT = 4;
    localparam int HOLD_BIT = 5;
    // Reset values
    localparam logic [13:0] LOCK_COUNT_RESET = 14'h2000;
    localparam logic [4:0] SEL_RESET = 5'h00;
    localparam logic [2:0] TYPE_RESET = 3'h6;
    localparam logic [2:0] PD_RESET = 3'h7;
    localparam logic HOLD_RESET = 1'b0;
    // Driver types
    localparam logic [2:0] TYPE_PUSH_PULL = 3'h3;
    localparam logic [2:0] TYPE_INVERTED = 3'h4;
    localparam logic [2:0] TYPE_OPEN_DRAIN = 3'h6;
    // Selector codes that need loop-two lock detect
    localparam logic [4:0] SEL_LOOP_TWO_LOCK = 5'h02;
    localparam logic [4:0] SEL_BOTH_LOCK = 5'h03;
    // Window limits in units of 0.1 ns
    localparam logic [7:0] WINDOW_1_TENTHS = 8'h0A;
    localparam logic [7:0] WINDOW_2_TENTHS = 8'h12;
    localparam logic [7:0] WINDOW_3_TENTHS = 8'h1A;
    typedef enum logic [1:0] {
        PLSC_WIN_RSVD = 2'b00,
        PLSC_WIN_1NS = 2'b01,
        PLSC_WIN_1P8NS = 2'b10,
        PLSC_WIN_2P6NS = 2'b11
    } plsc_window_t;
endpackage

// >>> plsc_lock_detect.sv
// Purpose: Loop-two digital lock detector
// Assumes: pd_tick is one pulse per phase-detector cycle, same clock
// Notes: Counter saturates at the programmed count
`timescale 1ns/100ps
module plsc_lock_detect #(
    parameter int CNT_W = 14
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic pd_tick,
    input wire logic [1:0] window_code,
    input wire logic [7:0] phase_error_tenths,
    input wire logic [CNT_W-1:0] target,
    output logic lock
);
    ////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic lock_reg;
    logic lock_next;
    logic [7:0] limit;
    logic in_window;
    logic reached;

    // Window limit per code; reserved code never in window
    assign limit = (window_code == plsc_pkg::PLSC_WIN_1NS) ? plsc_pkg::WINDOW_1_TENTHS :
                   (window_code == plsc_pkg::PLSC_WIN_1P8NS) ? plsc_pkg::WINDOW_2_TENTHS :
                   (window_code == plsc_pkg::PLSC_WIN_2P6NS) ? plsc_pkg::WINDOW_3_TENTHS : 8'h00;
    assign in_window = (phase_error_tenths < limit);
    // One bit wider so a full-scale count does not wrap and drop lock
    assign reached = (((CNT_W+1)'(cnt_reg) + 1'b1) >= (CNT_W+1)'(target));
    // Consecutive in-window cycles counted, any miss restarts
    assign cnt_next = !enable ? '0 :
                      !pd_tick ? cnt_reg :
                      !in_window ? '0 :
                      reached ? target : CNT_W'(cnt_reg + 1'b1);
    assign lock_next = !enable ? 1'b0 :
                       !pd_tick ? lock_reg :
                       (in_window && reached);
    assign lock = lock_reg;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_reg <= '0;
            lock_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            lock_reg <= lock_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    property p_miss_clears;
        @(posedge ref_clk) disable iff (rst)
        (enable && pd_tick && !in_window) |=> (!lock_reg && cnt_reg == '0);
    endproperty
    a_miss_clears: assert property (p_miss_clears)
        else $error("Lock held after out-of-window cycle");

    property p_rise_needs_count;
        @(posedge ref_clk) disable iff (rst)
        $rose(lock_reg) |-> ($past(cnt_reg) + 1'b1 >= $past(target)) && $past(pd_tick);
    endproperty
    a_rise_needs_count: assert property (p_rise_needs_count)
        else $error("Lock rose before programmed count");

    property p_reserved_window;
        @(posedge ref_clk) disable iff (rst)
        (window_code == plsc_pkg::PLSC_WIN_RSVD && pd_tick) |=> !lock_reg;
    endproperty
    a_reserved_window: assert property (p_reserved_window)
        else $error("Lock with reserved window code");
endmodule

// >>> plsc_regs.sv
// Purpose: Lock count, status pin two, loop-two powerdown and divider hold registers
// Assumes: Serial control port delivers decoded byte accesses on ref_clk
// Notes: Analog-side inputs are synchronised here
`timescale 1ns/100ps
module plsc_regs #(
    parameter logic [13:0] LOCK_COUNT_RESET = plsc_pkg::LOCK_COUNT_RESET
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [plsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [4:0] status_one_select,
    input wire logic lock_detect_force_on,
    input wire logic [1:0] lock_window_size,
    input wire logic pd_tick,
    input wire logic [7:0] phase_error_tenths,
    input wire logic loop_one_lock_in,
    input wire logic holdover_in,
    input wire logic dac_locked_in,
    input wire logic readback_bit_in,
    input wire logic dac_rail_in,
    input wire logic dac_low_in,
    input wire logic dac_high_in,
    input wire logic [5:0] divider_out_in,
    output logic status_pin_two_out,
    output logic status_pin_two_oe,
    output logic prescaler_powerdown,
    output logic loop_two_powerdown,
    output logic feedback_input_powerdown,
    output logic ref_divider_hold,
    output logic digital_lock_indication
);
    ////////////////////////////////////////////////////////////////
    logic [5:0] cnt_hi_reg;
    logic [7:0] cnt_lo_reg;
    logic [4:0] sel_reg;
    logic [2:0] type_reg;
    logic [2:0] pd_reg;
    logic hold_reg;
    logic [7:0] rdata_reg;
    logic pin_out_reg;
    logic pin_oe_reg;
    logic [12:0] sync1_reg;
    logic [12:0] sync2_reg;
    logic [5:0] div_prev_reg;
    logic [1:0] div_cnt_reg [6];
    logic lock_two;
    logic detect_en;
    logic loop_one_ok;
    logic [5:0] div_rise;
    logic [18:0] sources;
    logic pin_value;
    logic pin_out_next;
    logic pin_oe_next;
    logic [7:0] rdata_next;
    logic wr_hi;
    logic wr_lo;
    logic wr_sel;
    logic wr_pd;
    logic wr_hold;

    function automatic logic hit(input logic [plsc_pkg::ADDR_W-1:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_hi = reg_wr && hit(reg_addr, plsc_pkg::OFS_LOCK_COUNT_HIGH);
    assign wr_lo = reg_wr && hit(reg_addr, plsc_pkg::OFS_LOCK_COUNT_LOW);
    assign wr_sel = reg_wr && hit(reg_addr, plsc_pkg::OFS_STATUS_PIN_TWO_SELECT);
    assign wr_pd = reg_wr && hit(reg_addr, plsc_pkg::OFS_LOOP_TWO_POWERDOWN);
    assign wr_hold = reg_wr && hit(reg_addr, plsc_pkg::OFS_REF_DIVIDER_HOLD);

    // Readback with reserved bits zero
    assign rdata_next =
        !reg_rd ? rdata_reg :
        hit(reg_addr, plsc_pkg::OFS_LOCK_COUNT_HIGH) ? {2'b00, cnt_hi_reg} :
        hit(reg_addr, plsc_pkg::OFS_LOCK_COUNT_LOW) ? cnt_lo_reg :
        hit(reg_addr, plsc_pkg::OFS_STATUS_PIN_TWO_SELECT) ? {sel_reg, type_reg} :
        hit(reg_addr, plsc_pkg::OFS_LOOP_TWO_POWERDOWN) ? {1'b0, pd_reg, 4'h0} :
        hit(reg_addr, plsc_pkg::OFS_REF_DIVIDER_HOLD) ? {2'b00, hold_reg, 5'h00} : 8'h00;

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cnt_hi_reg <= LOCK_COUNT_RESET[13:8];
            cnt_lo_reg <= LOCK_COUNT_RESET[7:0];
            sel_reg <= plsc_pkg::SEL_RESET;
            type_reg <= plsc_pkg::TYPE_RESET;
            pd_reg <= plsc_pkg::PD_RESET;
            hold_reg <= plsc_pkg::HOLD_RESET;
            rdata_reg <= 8'h00;
        end
        else
        begin
            if (wr_hi) cnt_hi_reg <= reg_wdata[5:0];
            if (wr_lo) cnt_lo_reg <= reg_wdata;
            if (wr_sel) sel_reg <= reg_wdata[plsc_pkg::SEL_LSB +: 5];
            if (wr_sel) type_reg <= reg_wdata[plsc_pkg::TYPE_LSB +: 3];
            if (wr_pd) pd_reg <= reg_wdata[plsc_pkg::FB_PD_BIT +: 3];
            if (wr_hold) hold_reg <= reg_wdata[plsc_pkg::HOLD_BIT];
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Two-stage synchronisers for analog-side levels
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            div_prev_reg <= '0;
        end
        else
        begin
            sync1_reg <= {divider_out_in, dac_high_in, dac_low_in, dac_rail_in,
                          readback_bit_in, dac_locked_in, holdover_in, loop_one_lock_in};
            sync2_reg <= sync1_reg;
            div_prev_reg <= sync2_reg[12:7];
        end
    end

    assign div_rise = sync2_reg[12:7] & ~div_prev_reg;

    // Divide each divider output by two and four
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_div
            always_ff @(posedge ref_clk)
            begin
                if (rst)
                    div_cnt_reg[gi] <= 2'h0;
                else if (div_rise[gi])
                    div_cnt_reg[gi] <= div_cnt_reg[gi] + 2'h1;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    assign detect_en = !pd_reg[1] && (lock_detect_force_on ||
        sel_reg == plsc_pkg::SEL_LOOP_TWO_LOCK || sel_reg == plsc_pkg::SEL_BOTH_LOCK ||
        status_one_select == plsc_pkg::SEL_LOOP_TWO_LOCK ||
        status_one_select == plsc_pkg::SEL_BOTH_LOCK);

    plsc_lock_detect #(
        .CNT_W(plsc_pkg::CNT_W)
    ) u_lock (
        .ref_clk(ref_clk),
        .rst(rst),
        .enable(detect_en),
        .pd_tick(pd_tick),
        .window_code(lock_window_size),
        .phase_error_tenths(phase_error_tenths),
        .target({cnt_hi_reg, cnt_lo_reg}),
        .lock(lock_two)
    );

    assign loop_one_ok = sync2_reg[0] && !hold_reg;

    // Selector sources, index equals selector code
    assign sources = {div_cnt_reg[4][1], div_cnt_reg[4][0], div_cnt_reg[3][1], div_cnt_reg[3][0],
                      div_cnt_reg[2][1], div_cnt_reg[2][0], div_cnt_reg[1][1], div_cnt_reg[1][0],
                      sync2_reg[6], sync2_reg[5], sync2_reg[4], sync2_reg[3], 1'b0,
                      sync2_reg[2], sync2_reg[1], loop_one_ok && lock_two, lock_two,
                      loop_one_ok, 1'b0};
    assign pin_value = (sel_reg <= 5'h12) ? sources[sel_reg] : 1'b0;

    // Driver type: reserved codes release the pin
    assign pin_out_next = (type_reg == plsc_pkg::TYPE_PUSH_PULL) ? pin_value :
                          (type_reg == plsc_pkg::TYPE_INVERTED) ? !pin_value : 1'b0;
    assign pin_oe_next = (type_reg == plsc_pkg::TYPE_PUSH_PULL) ||
                         (type_reg == plsc_pkg::TYPE_INVERTED) ||
                         ((type_reg == plsc_pkg::TYPE_OPEN_DRAIN) && !pin_value);

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end
        else
        begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign status_pin_two_out = pin_out_reg;
    assign status_pin_two_oe = pin_oe_reg;
    assign prescaler_powerdown = pd_reg[2];
    assign loop_two_powerdown = pd_reg[1];
    assign feedback_input_powerdown = pd_reg[0];
    assign ref_divider_hold = hold_reg;
    assign digital_lock_indication = lock_two;

    ////////////////////////////////////////////////////////////////
    property p_reset_values;
        @(posedge ref_clk) $fell(rst) |-> (pd_reg == 3'h7 && type_reg == 3'h6 && !hold_reg && sel_reg == 5'h00);
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("Wrong reset values");

    property p_pd_write;
        @(posedge ref_clk) disable iff (rst)
        wr_pd |=> (prescaler_powerdown == $past(reg_wdata[6]) && loop_two_powerdown == $past(reg_wdata[5])
                   && feedback_input_powerdown == $past(reg_wdata[4]));
    endproperty
    a_pd_write: assert property (p_pd_write)
        else $error("Powerdown bits not taken from write");

    property p_reserved_read;
        @(posedge ref_clk) disable iff (rst)
        (reg_rd && reg_addr == 12'h173) |=> (reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0);
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("Reserved bits read nonzero");

    property p_hold_no_lock;
        @(posedge ref_clk) disable iff (rst)
        (hold_reg && sel_reg == 5'h01 && type_reg == 3'h3) |=> !status_pin_two_out;
    endproperty
    a_hold_no_lock: assert property (p_hold_no_lock)
        else $error("Loop one lock shown while divider held");

    property p_inverted_low;
        @(posedge ref_clk) disable iff (rst)
        (type_reg == 3'h4 && sel_reg == 5'h00) |=> (status_pin_two_out && status_pin_two_oe);
    endproperty
    a_inverted_low: assert property (p_inverted_low)
        else $error("Inverted push-pull wrong");

    property p_open_drain_low;
        @(posedge ref_clk) disable iff (rst)
        (type_reg == 3'h6 && sel_reg == 5'h00) |=> (status_pin_two_oe && !status_pin_two_out);
    endproperty
    a_open_drain_low: assert property (p_open_drain_low)
        else $error("Open drain not pulling low");

    property p_detect_off;
        @(posedge ref_clk) disable iff (rst)
        !detect_en |=> !digital_lock_indication;
    endproperty
    a_detect_off: assert property (p_detect_off)
        else $error("Lock shown with detector off");

    property p_count_readback;
        @(posedge ref_clk) disable iff (rst)
        wr_hi ##1 !wr_hi ##1 !wr_hi ##1 (reg_rd && reg_addr == 12'h16A)
            |=> reg_rdata == {2'b00, $past(reg_wdata[5:0], 4)};
    endproperty
    a_count_readback: assert property (p_count_readback)
        else $error("Lock count high readback wrong");
endmodule

// >>> plsc_host_model.sv
// Purpose: Host side of the serial control port, byte register accesses
// Assumes: Strobes change on falling ref_clk edges, one pulse per access
// Notes: Released lines carry inverted values so stale data is not seen
`timescale 1ns/100ps
module plsc_host_model (
    input wire logic ref_clk,
    input wire logic [4:0] status_one_select,
    input wire logic [7:0] reg_rdata,
    output logic [11:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial
    begin
        reg_addr = 12'h000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    ////////////////////////////////////////////////////////////////
    // Zero count is never sent
    task automatic set_count(input logic [13:0] c);
        if (c != 14'h0000)
        begin
            wr(plsc_pkg::OFS_LOCK_COUNT_HIGH, {2'b00, c[13:8]});
            wr(plsc_pkg::OFS_LOCK_COUNT_LOW, c[7:0]);
        end
    endtask
    // Loop-two reference divider only with pin one off the lock codes
    task automatic set_pin_two(input logic [4:0] sel, input logic [2:0] typ);
        if (!((sel == 5'h11 || sel == 5'h12) && (status_one_select == 5'h02 || status_one_select == 5'h03)))
            wr(plsc_pkg::OFS_STATUS_PIN_TWO_SELECT, {sel, typ});
    endtask
endmodule

// >>> test_plsc_regs.sv
// Purpose: Self-checking bench for the loop-two lock/status control slice
// Assumes: Inputs change on falling ref_clk edges
// Notes: Lock count boundary run takes about 16k cycles
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
        $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
        mismatches++; \
    end
module test_plsc_regs;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] status_one_select = 5'h00;
    logic lock_detect_force_on = 1'b0;
    logic [1:0] lock_window_size = 2'h1;
    logic pd_tick = 1'b0;
    logic [7:0] phase_error_tenths = 8'h00;
    logic [6:0] src = 7'h00;
    logic [5:0] divider_out_in = 6'h00;
    logic [10:0] follow = 11'h7B2;
    logic [11:0] reg_addr;
    logic reg_wr, reg_rd, pin_out, pin_oe, pre_pd, loop_pd, fb_pd, hold, lock;
    logic [7:0] reg_wdata, reg_rdata, rv;
    int mismatches = 0;
    int checks_done = 0;
    plsc_regs dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .status_one_select(status_one_select),
        .lock_detect_force_on(lock_detect_force_on), .lock_window_size(lock_window_size), .pd_tick(pd_tick),
        .phase_error_tenths(phase_error_tenths), .loop_one_lock_in(src[0]), .holdover_in(src[1]),
        .dac_locked_in(src[2]), .readback_bit_in(src[3]), .dac_rail_in(src[4]), .dac_low_in(src[5]),
        .dac_high_in(src[6]), .divider_out_in(divider_out_in), .status_pin_two_out(pin_out),
        .status_pin_two_oe(pin_oe), .prescaler_powerdown(pre_pd), .loop_two_powerdown(loop_pd),
        .feedback_input_powerdown(fb_pd), .ref_divider_hold(hold), .digital_lock_indication(lock));
    plsc_host_model host_u (.ref_clk(ref_clk), .status_one_select(status_one_select), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    always #5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] ex, input string nm);
        host_u.rd(a, rv);
        `CHK(nm, ex, rv);
    endtask
    task automatic ticks(input int n, input logic [7:0] ph);
        repeat (n)
        begin
            @(negedge ref_clk);
            pd_tick = 1'b1;
            phase_error_tenths = ph;
        end
        @(negedge ref_clk);
        pd_tick = 1'b0;
        phase_error_tenths = ~ph;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic pin(input logic [4:0] s, input logic [2:0] t, input logic [1:0] ex, input string nm);
        host_u.set_pin_two(s, t);
        repeat (4) @(negedge ref_clk);
        `CHK(nm, ex, {pin_oe, pin_out});
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK("pd_hold", 4'hE, {pre_pd, loop_pd, fb_pd, hold});
        `CHK("pin_rst", 2'b10, {pin_oe, pin_out});
        rchk(plsc_pkg::OFS_LOCK_COUNT_HIGH, {2'b00, plsc_pkg::LOCK_COUNT_RESET[13:8]}, "cnt_hi");
        rchk(plsc_pkg::OFS_LOCK_COUNT_LOW, plsc_pkg::LOCK_COUNT_RESET[7:0], "cnt_lo");
        rchk(plsc_pkg::OFS_STATUS_PIN_TWO_SELECT, 8'h06, "sel_rst");
        rchk(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h70, "pd_rst");
        rchk(plsc_pkg::OFS_REF_DIVIDER_HOLD, 8'h00, "hold_rst");
        rchk(12'h16C, 8'h00, "unmapped");
    endtask
    task automatic t_rw;
        host_u.wr(plsc_pkg::OFS_LOCK_COUNT_HIGH, 8'hFF);
        rchk(plsc_pkg::OFS_LOCK_COUNT_HIGH, 8'h3F, "cnt_hi_rw");
        host_u.wr(plsc_pkg::OFS_REF_DIVIDER_HOLD, 8'hFF);
        `CHK("hold_on", 1'b1, hold);
        rchk(plsc_pkg::OFS_REF_DIVIDER_HOLD, 8'h20, "hold_rw");
        host_u.wr(plsc_pkg::OFS_REF_DIVIDER_HOLD, 8'h00);
        `CHK("hold_off", 1'b0, hold);
        host_u.wr(12'h16C, 8'hFF);
        rchk(12'h16C, 8'h00, "unmapped_wr");
        for (int b = 4; b < 7; b++)
        begin
            host_u.wr(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h8F | (8'h01 << b));
            `CHK("pd_bit", 3'b001 << (b - 4), {pre_pd, loop_pd, fb_pd});
            rchk(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h01 << b, "pd_rw");
        end
    endtask
    task automatic t_lock;
        host_u.wr(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h00);
        lock_detect_force_on = 1'b1;
        host_u.set_count(14'h0003);
        for (int w = 1; w < 4; w++)
        begin
            lock_window_size = w[1:0];
            ticks(2, 8'(1 + 8 * w));
            `CHK("lock_early", 1'b0, lock);
            ticks(1, 8'(1 + 8 * w));
            `CHK("lock_win", 1'b1, lock);
            ticks(1, 8'(2 + 8 * w));
            `CHK("lock_out", 1'b0, lock);
        end
        lock_window_size = 2'h0;
        ticks(4, 8'h00);
        `CHK("lock_code0", 1'b0, lock);
        lock_window_size = 2'h1;
        lock_detect_force_on = 1'b0;
        ticks(3, 8'h00);
        `CHK("lock_off", 1'b0, lock);
        status_one_select = 5'h02;
        ticks(3, 8'h00);
        `CHK("lock_pin1", 1'b1, lock);
        status_one_select = 5'h00;
        host_u.set_pin_two(5'h02, plsc_pkg::TYPE_PUSH_PULL);
        ticks(3, 8'h00);
        repeat (2) @(negedge ref_clk);
        `CHK("lock_pin2", 2'b11, {lock, pin_out});
        host_u.wr(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h20);
        `CHK("lock_pd", 1'b0, lock);
        host_u.set_count(14'h3FFF);
        host_u.wr(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h00);
        ticks(16382, 8'h00);
        `CHK("lock_max_early", 1'b0, lock);
        ticks(1, 8'h00);
        `CHK("lock_max", 1'b1, lock);
        host_u.wr(plsc_pkg::OFS_LOOP_TWO_POWERDOWN, 8'h20);
    endtask
    task automatic t_pin;
        for (int s = 0; s < 11; s++)
            for (int v = 0; v < 2; v++)
            begin
                src = v[0] ? 7'h7F : 7'h00;
                pin(s[4:0], plsc_pkg::TYPE_PUSH_PULL, {1'b1, v[0] & follow[s]}, "pin_sel");
            end
        pin(5'h00, plsc_pkg::TYPE_INVERTED, 2'b11, "pin_inv");
        pin(5'h00, plsc_pkg::TYPE_OPEN_DRAIN, 2'b10, "pin_od_low");
        pin(5'h04, plsc_pkg::TYPE_OPEN_DRAIN, 2'b00, "pin_od_high");
        pin(5'h04, 3'h5, 2'b00, "pin_rsvd_type");
        host_u.wr(plsc_pkg::OFS_REF_DIVIDER_HOLD, 8'h20);
        pin(5'h01, plsc_pkg::TYPE_PUSH_PULL, 2'b10, "pin_hold");
        host_u.wr(plsc_pkg::OFS_REF_DIVIDER_HOLD, 8'h00);
        pin(5'h01, plsc_pkg::TYPE_PUSH_PULL, 2'b11, "pin_unhold");
    endtask
    task automatic t_div;
        int rises;
        int ex;
        int k;
        logic prev;
        for (int s = 11; s < 19; s++)
        begin
            host_u.set_pin_two(s[4:0], plsc_pkg::TYPE_PUSH_PULL);
            k = (s - 11) / 2 + 1;
            ex = (s % 2 == 1) ? 10 : 5;
            rises = 0;
            prev = pin_out;
            for (int c = 0; c < 400; c++)
            begin
                @(negedge ref_clk);
                if (c % 10 == 0)
                    divider_out_in[k] = ~divider_out_in[k];
                rises += int'(pin_out & ~prev);
                prev = pin_out;
            end
            divider_out_in = 6'h00;
            `CHK("div_rises", 1'b1, 1'(rises >= ex - 1 && rises <= ex + 1));
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_reset;
        t_rw;
        t_lock;
        t_pin;
        t_div;
        test_done;
    end
    initial
    begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        test_done;
    end
endmodule
